// ===== design/kms_consts.vh
// Purpose: Constants for the key matrix scan controller
// Assumes: Included by bare name from design/kms_scan.v
// Notes:   Times are counted in periods T of the scan time base
`ifndef KMS_CONSTS_VH
`define KMS_CONSTS_VH

// ****************************************************************
// Register offsets
// ****************************************************************
`define KMS_ADDR_W        4
`define KMS_OFF_CTRL      4'h0
`define KMS_OFF_STATUS    4'h4
`define KMS_OFF_KEYS      4'h8

// ****************************************************************
// Control field positions and reset value
// ****************************************************************
`define KMS_CTRL_CFG_LSB  0
`define KMS_CTRL_CFG_MSB  2
`define KMS_CTRL_DIS_BIT  3
`define KMS_CTRL_SLP_BIT  4
`define KMS_CTRL_OSC_BIT  5
`define KMS_CTRL_RST      6'h08

// ****************************************************************
// Status field positions
// ****************************************************************
`define KMS_ST_REQ_BIT    0
`define KMS_ST_SCAN_BIT   1
`define KMS_ST_SACK_BIT   2
`define KMS_ST_SRST_BIT   3
`define KMS_ST_DISP_BIT   4

// ****************************************************************
// Timing in periods T and matrix dimensions
// ****************************************************************
`define KMS_SCAN_T        10'd288
`define KMS_REQ_T         10'd615
`define KMS_LINES         6
`define KMS_RETURNS       5
`define KMS_SLOT_T        6'd48
`define KMS_SLOT_LAST     6'd47
`define KMS_LINE_LAST     3'd5

// ****************************************************************
// Scan line levels per configuration code
// ****************************************************************
`define KMS_CFG0          6'h3f
`define KMS_CFG1          6'h01
`define KMS_CFG2          6'h02
`define KMS_CFG3          6'h04
`define KMS_CFG4          6'h08
`define KMS_CFG5          6'h20
`define KMS_CFG6          6'h10
`define KMS_CFG7          6'h00

`endif

// ===== design/kms_scan.v
// Purpose: Key matrix scanning with read request on an open-drain line
// Assumes: Pins are asynchronous to clock; reset_n synchronous, active low
// Notes:   The scan time base T is the rising edge rate of oscillator_pin
//
// Function
// RL1: Scan lines follow the three-bit configuration field
// RL2: Pressed high line starts scan, repeat until release
// RL3: Every pressed key sets its own key bit
// RL4: Press held 615 T pulls request low
// RL5: Chip enable high releases the request line
// RL6: Controller answers request by reading key data
// RL7: Key read clears request, then scans again
// RL8: Sleep key press restarts time base, then scans
// RL9: Key read in sleep keeps sleep set
// RL10: Config 101 leaves only sixth line high
// RL11: Scan disable bit blocks every key scan
// RL12: Disable written during scan stops the scan
// RL13: Disable during request zeroes keys, releases line
// RL14: Only writing disable to zero re-enables scanning
// RL15: System reset blanks display, stops scan, zeroes keys
// RL16: Reset released on chip enable fall after data
// RL17: After reset release display on, scanning allowed
// RL18: Controller may drop words with three set bits
// RL19: Two 288 T scans must agree to accept
// RL20: Key bit index is five times line plus return
// RL21: Sleep bit stops display clock except during scans
// RL22: Request is active-low open drain, else released
`timescale 1ns/100ps
`include "kms_consts.vh"

module kms_scan (
  // Clock and reset
  input  wire        clock,
  input  wire        reset_n,
  // Register port
  input  wire [3:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata,
  // Key matrix pins
  output wire [5:0]  scan_drive_lines,
  input  wire [4:0]  key_return_inputs,
  // Time base and serial bus pins
  input  wire        oscillator_pin,
  input  wire        chip_enable,
  output wire        key_req_n_o,
  output wire        key_req_n_oe,
  // System reset sources
  input  wire        supply_drop_detector,
  input  wire        disp_data_done,
  // Display and oscillator control
  output wire        display_on,
  output wire        disp_clk_en,
  output wire        osc_run,
  output wire        osc_source_select
);

  // ****************************************************************
  // States
  // ****************************************************************
  localparam [2:0] ST_IDLE  = 3'd0;   // Waiting for a press
  localparam [2:0] ST_SCAN1 = 3'd1;   // First pass
  localparam [2:0] ST_SCAN2 = 3'd2;   // Second pass
  localparam [2:0] ST_HOLD  = 3'd3;   // Waiting out the request time
  localparam [2:0] ST_REQ   = 3'd4;   // Request pending

  reg  [2:0]  state_q;                // Scan state
  reg  [5:0]  ctrl_q;                 // Control register
  reg         ctrl_seen_q;            // Control written since reset began
  reg         srst_q;                 // System reset active
  reg         req_q;                  // Read request pending
  reg         sack_q;                 // Sleep state at press time
  reg  [29:0] key_bits;               // Accepted key data
  reg  [29:0] pass1_q;                // First pass result
  reg  [29:0] pass2_q;                // Second pass result
  reg  [9:0]  t_cnt_q;                // T count from scan start
  reg  [5:0]  sub_q;                  // T count inside one line slot
  reg  [2:0]  line_q;                 // Line being driven
  reg  [2:0]  osc_s_q;                // Time base synchroniser
  reg         osc_lv_q;               // Filtered time base level
  reg  [2:0]  ce_s_q;                 // Chip enable synchroniser
  reg         ce_lv_q;                // Filtered chip enable level
  reg  [14:0] ki_s_q;                 // Return line synchronisers
  reg  [4:0]  ki_lv_q;                // Filtered return levels
  reg  [5:0]  cfg_lines;              // Idle line levels
  reg  [5:0]  drive;                  // Line levels this cycle
  integer     i;                      // Synchroniser loop index
  integer     j;                      // Pass slot loop index

  wire [2:0]  cfg      = ctrl_q[`KMS_CTRL_CFG_MSB:`KMS_CTRL_CFG_LSB];
  wire        scan_dis = ctrl_q[`KMS_CTRL_DIS_BIT];
  wire        sleep    = ctrl_q[`KMS_CTRL_SLP_BIT];
  wire        scanning = (state_q == ST_SCAN1) || (state_q == ST_SCAN2)
                         || (state_q == ST_HOLD);
  wire        wr_ctrl  = reg_wr && (reg_addr == `KMS_OFF_CTRL);
  wire        rd_keys  = reg_rd && (reg_addr == `KMS_OFF_KEYS);
  wire        dis_set  = wr_ctrl && reg_wdata[`KMS_CTRL_DIS_BIT];
  wire        osc_lv_d = (osc_s_q[1] == osc_s_q[2]) ? osc_s_q[2] : osc_lv_q;
  wire        ce_lv_d  = (ce_s_q[1] == ce_s_q[2]) ? ce_s_q[2] : ce_lv_q;
  wire        ce_fall  = ce_lv_q && !ce_lv_d;
  wire        press    = |ki_lv_q;
  wire        start_ok = !scan_dis && !srst_q && press;
  // Time base runs unless sleeping outside a scan, ST_REQ included; a press in sleep wakes it
  wire        run      = !sleep || scanning || start_ok;
  wire        tick     = run && osc_lv_d && !osc_lv_q;
  wire        slot_end = tick && (sub_q == `KMS_SLOT_LAST);
  wire        pass_end = slot_end && (line_q == `KMS_LINE_LAST);

  // ****************************************************************
  // Pin synchronisers; a level counts once stages two and three agree
  // ****************************************************************
  always @(posedge clock) begin
    if (!reset_n) begin
      osc_s_q  <= 3'h0;
      osc_lv_q <= 1'b0;
      ce_s_q   <= 3'h0;
      ce_lv_q  <= 1'b0;
      ki_s_q   <= 15'h0;
      ki_lv_q  <= 5'h0;
    end else begin
      osc_s_q  <= {osc_s_q[1:0], oscillator_pin};
      osc_lv_q <= osc_lv_d;
      ce_s_q   <= {ce_s_q[1:0], chip_enable};
      ce_lv_q  <= ce_lv_d;
      ki_s_q   <= {ki_s_q[9:0], key_return_inputs};
      for (i = 0; i < `KMS_RETURNS; i = i + 1) begin
        if (ki_s_q[5 + i] == ki_s_q[10 + i])
          ki_lv_q[i] <= ki_s_q[10 + i];
      end
    end
  end

  // ****************************************************************
  // Scan line levels
  // ****************************************************************
  // Idle levels from the configuration code
  always @* begin
    case (cfg) // RL1
      3'd0:    cfg_lines = `KMS_CFG0;
      3'd1:    cfg_lines = `KMS_CFG1;
      3'd2:    cfg_lines = `KMS_CFG2;
      3'd3:    cfg_lines = `KMS_CFG3;
      3'd4:    cfg_lines = `KMS_CFG4;
      3'd5:    cfg_lines = `KMS_CFG5; // RL10
      3'd6:    cfg_lines = `KMS_CFG6;
      default: cfg_lines = `KMS_CFG7;
    endcase
  end

  // During a pass one line is high at a time
  always @* begin
    drive = cfg_lines;
    if ((state_q == ST_SCAN1) || (state_q == ST_SCAN2)) begin
      drive = 6'h00;
      drive[line_q] = 1'b1;
    end
  end

  assign scan_drive_lines = drive;

  // ****************************************************************
  // Control register and system reset
  // ****************************************************************
  always @(posedge clock) begin
    if (!reset_n) begin
      ctrl_q      <= `KMS_CTRL_RST;
      ctrl_seen_q <= 1'b0;
      srst_q      <= 1'b1;
    end else begin
      if (wr_ctrl)
        ctrl_q <= reg_wdata[5:0]; // RL14 RL21
      if (supply_drop_detector) begin
        srst_q      <= 1'b1; // RL15
        ctrl_seen_q <= 1'b0;
      end else begin
        if (wr_ctrl)
          ctrl_seen_q <= 1'b1;
        // Release only on the closing chip enable fall of a full load
        if (ce_fall && ctrl_seen_q && disp_data_done)
          srst_q <= 1'b0; // RL16 RL17
      end
    end
  end

  // ****************************************************************
  // Scan sequencer
  // ****************************************************************
  always @(posedge clock) begin
    if (!reset_n) begin
      state_q  <= ST_IDLE;
      req_q    <= 1'b0;
      sack_q   <= 1'b0;
      key_bits <= 30'h0;
      pass1_q  <= 30'h0;
      pass2_q  <= 30'h0;
      t_cnt_q  <= 10'h0;
      sub_q    <= 6'h0;
      line_q   <= 3'h0;
    end else if (srst_q || supply_drop_detector) begin
      // Held stopped with empty key data
      state_q  <= ST_IDLE; // RL15
      req_q    <= 1'b0;
      key_bits <= 30'h0;
    end else if (dis_set) begin
      // Disable stops a pass and withdraws a request
      state_q <= ST_IDLE; // RL12
      if (req_q) begin
        req_q    <= 1'b0; // RL13
        key_bits <= 30'h0;
      end
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (start_ok) begin
            state_q <= ST_SCAN1; // RL2 RL8 RL11
            sack_q  <= sleep;
            t_cnt_q <= 10'h0;
            sub_q   <= 6'h0;
            line_q  <= 3'h0;
            pass1_q <= 30'h0;
          end
        end
        ST_SCAN1, ST_SCAN2: begin
          if (tick) begin
            t_cnt_q <= t_cnt_q + 10'd1;
            sub_q   <= slot_end ? 6'h0 : sub_q + 6'd1;
          end
          if (slot_end) begin
            // Each return line lands in its own bit
            for (j = 0; j < `KMS_LINES; j = j + 1) begin
              if (line_q == j[2:0]) begin
                if (state_q == ST_SCAN1)
                  pass1_q[j*5 +: 5] <= ki_lv_q; // RL3 RL20
                else
                  pass2_q[j*5 +: 5] <= ki_lv_q; // RL20
              end
            end
            line_q <= (line_q == `KMS_LINE_LAST) ? 3'h0 : line_q + 3'd1;
          end
          if (pass_end)
            state_q <= (state_q == ST_SCAN1) ? ST_SCAN2 : ST_HOLD; // RL19
        end
        ST_HOLD: begin
          if (pass1_q != pass2_q) begin
            // Passes differ: scan again from the start
            state_q <= ST_SCAN1; // RL19
            t_cnt_q <= 10'h0;
            sub_q   <= 6'h0;
            line_q  <= 3'h0;
          end else if (pass1_q == 30'h0) begin
            state_q <= ST_IDLE; // RL2
          end else begin
            if (tick)
              t_cnt_q <= t_cnt_q + 10'd1;
            if (tick && (t_cnt_q >= `KMS_REQ_T - 10'd1)) begin
              state_q  <= ST_REQ; // RL4
              req_q    <= 1'b1;
              key_bits <= pass1_q;
            end
          end
        end
        ST_REQ: begin
          if (rd_keys) begin
            // Read clears the request, sleep bit untouched
            req_q   <= 1'b0; // RL7 RL9
            state_q <= ST_SCAN1;
            t_cnt_q <= 10'h0;
            sub_q   <= 6'h0;
            line_q  <= 3'h0;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // Request line, display and oscillator control
  // ****************************************************************
  assign key_req_n_o       = 1'b0;                   // RL22
  assign key_req_n_oe      = req_q && !ce_lv_q;     // RL5 RL22
  assign display_on        = !srst_q && !sleep;     // RL15 RL17
  assign disp_clk_en       = !srst_q && (!sleep || scanning); // RL21
  assign osc_run           = run;                   // RL8
  assign osc_source_select = ctrl_q[`KMS_CTRL_OSC_BIT];

  // ****************************************************************
  // Register read port, data one cycle after the strobe
  // ****************************************************************
  always @(posedge clock) begin
    if (!reset_n) begin
      reg_rdata <= 32'h0;
    end else if (reg_rd) begin
      case (reg_addr)
        `KMS_OFF_CTRL:   reg_rdata <= {26'h0, ctrl_q};
        `KMS_OFF_STATUS: reg_rdata <= {27'h0, display_on, srst_q, sack_q,
                                       scanning, req_q};
        `KMS_OFF_KEYS:   reg_rdata <= {sack_q, 1'b0, key_bits};
        default:         reg_rdata <= 32'h0;
      endcase
    end else begin
      reg_rdata <= 32'h0;
    end
  end

endmodule // kms_scan

// ===== sim/kms_scan_chk.sv
// Purpose: Port checks for the key matrix scan controller
// Assumes: Bound to kms_scan; one clock domain
// Notes:   Chip enable acts only after a short synchroniser
`timescale 1ns/100ps
module kms_scan_chk (
  // Clock and reset
  input logic        clock,
  input logic        reset_n,
  // Register port
  input logic [3:0]  reg_addr,
  input logic [31:0] reg_wdata,
  input logic        reg_wr,
  input logic        reg_rd,
  // Pins and status
  input logic [5:0]  scan_drive_lines,
  input logic        chip_enable,
  input logic        key_req_n_o,
  input logic        key_req_n_oe,
  input logic        supply_drop_detector,
  input logic        display_on,
  input logic        disp_clk_en
);
  // Control register write decode
  wire ctl_wr = reg_wr && reg_addr == 4'h0;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  // ********************
  // Assertions
  // ********************
  a_od_low: assert property (key_req_n_o == 1'b0)
    else $error("request data pin not low");
  a_ce_release: assert property (chip_enable [*6] |-> !key_req_n_oe)
    else $error("request driven while chip enable high");
  a_read_clear: assert property (reg_rd && reg_addr == 4'h8 |=> !key_req_n_oe)
    else $error("key read left request pending");
  a_cfg_five: assert property (ctl_wr && reg_wdata[3:0] == 4'hd |=> scan_drive_lines == 6'h20)
    else $error("code five does not leave only line six high");
  a_dis_drop: assert property (ctl_wr && reg_wdata[3] |=> !key_req_n_oe)
    else $error("disable write left request pending");
  a_drop_blank: assert property (supply_drop_detector |=> !display_on && !key_req_n_oe)
    else $error("system reset did not blank and release");
  a_req_hold: assert property (!chip_enable [*5] ##0
    (key_req_n_oe && !reg_rd && !reg_wr && !supply_drop_detector) |=> key_req_n_oe)
    else $error("request dropped without cause");
  a_sleep_blank: assert property (ctl_wr && reg_wdata[4] |=> !display_on)
    else $error("display still on in sleep");
  a_disp_clk: assert property (display_on |-> disp_clk_en)
    else $error("display clock stopped in normal mode");

  // Main scenarios reached
  c_req: cover property ($rose(key_req_n_oe));
  c_read: cover property (reg_rd && reg_addr == 4'h8 && key_req_n_oe);
  c_wake: cover property (!display_on && disp_clk_en);
endmodule // kms_scan_chk

// ===== sim/kms_key_matrix.sv
// Purpose: Key matrix, external time base and pull-up beside kms_scan
// Assumes: pressed holds one bit per key, line-major
// Notes:   Keys are ideal switches with series diodes, no bounce
`timescale 1ns/100ps
module kms_key_matrix (
  // Key state from the bench
  input  logic [29:0] pressed,
  // Device pins
  input  logic [5:0]  scan_drive_lines,
  output logic [4:0]  key_return_inputs,
  input  logic        key_req_n_o,
  input  logic        key_req_n_oe,
  output logic        req_line,
  output logic        oscillator_pin
);
  // Free running external clock, 80 ns period
  initial begin
    oscillator_pin = 1'b0;
    forever #40 oscillator_pin = ~oscillator_pin;
  end

  // A return line sees every pressed key on a high scan line
  always_comb begin
    key_return_inputs = 5'h00;
    for (int l = 0; l < 6; l++) begin
      for (int r = 0; r < 5; r++) begin
        if (scan_drive_lines[l] && pressed[5*l+r]) key_return_inputs[r] = 1'b1;
      end
    end
  end

  // Open-drain request line with pull-up
  assign req_line = key_req_n_oe ? key_req_n_o : 1'b1;
endmodule // kms_key_matrix

// ===== sim/kms_scan_tb_top.sv
// Purpose: Self-checking bench for the key matrix scan controller
// Assumes: One T is ten clocks; pins pass short synchronisers
// Notes:   Request times are bounded around 615 T
`timescale 1ns/100ps
`include "kms_consts.vh"
module kms_scan_tb_top;
  logic        clock, reset_n, reg_wr, reg_rd;          // Clock, reset, strobes
  logic [3:0]  reg_addr;                                 // Register address
  logic [31:0] reg_wdata, reg_rdata, d;                  // Bus data
  logic [5:0]  scan_drive_lines;                         // Scan lines
  logic [4:0]  key_return_inputs;                        // Return lines
  logic [29:0] pressed;                                  // Keys held down
  logic        oscillator_pin, chip_enable, req_line;    // Link pins
  logic        key_req_n_o, key_req_n_oe, osc_run, osc_source_select;
  logic        supply_drop_detector, disp_data_done, display_on, disp_clk_en;
  logic [5:0]  lut [8];                                  // Line levels per code
  int          err_count, comparisons, n;                // Tallies

  kms_scan kms_scan_inst (
    .clock(clock), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .scan_drive_lines(scan_drive_lines), .key_return_inputs(key_return_inputs),
    .oscillator_pin(oscillator_pin), .chip_enable(chip_enable),
    .key_req_n_o(key_req_n_o), .key_req_n_oe(key_req_n_oe),
    .supply_drop_detector(supply_drop_detector), .disp_data_done(disp_data_done),
    .display_on(display_on), .disp_clk_en(disp_clk_en), .osc_run(osc_run),
    .osc_source_select(osc_source_select));
  kms_key_matrix kms_key_matrix_inst (
    .pressed(pressed), .scan_drive_lines(scan_drive_lines),
    .key_return_inputs(key_return_inputs), .key_req_n_o(key_req_n_o),
    .key_req_n_oe(key_req_n_oe), .req_line(req_line), .oscillator_pin(oscillator_pin));

  // 125 MHz clock
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  // ********************
  // Helpers
  // ********************
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge clock);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clock);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  // Bounded wait for the request line to go low; n counts clocks
  task automatic wait_req(input int lim);
    n = 0;
    while (req_line !== 1'b0 && n < lim) begin
      @(posedge clock);
      n++;
    end
    #1;
  endtask
  task automatic put(input logic [29:0] k, input logic ce);
    @(posedge clock);
    pressed     <= k;
    chip_enable <= ce;
    tick(6);
  endtask
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // ********************
  // Scenarios
  // ********************
  task automatic t_reset_lines;
    // Reset state, unmapped read and every line code
    chk("display", display_on, 1'b0);
    chk("req line", req_line, 1'b1);
    rd(`KMS_OFF_CTRL);
    chk("ctrl", d, 32'h8);
    rd(4'hc);
    chk("unmapped", d, 32'h0);
    for (int i = 0; i < 8; i++) begin
      wr(`KMS_OFF_CTRL, 32'h8 | i);
      chk("lines", scan_drive_lines, lut[i]);
    end
    $display("done reset and lines");
  endtask
  task automatic t_release;
    // System reset holds until display data done and chip enable falls
    wr(`KMS_OFF_CTRL, 32'h0);
    put(30'h0, 1'b1);
    put(30'h0, 1'b0);
    chk("held", display_on, 1'b0);
    disp_data_done <= 1'b1;
    put(30'h0, 1'b1);
    put(30'h0, 1'b0);
    chk("released", display_on, 1'b1);
    $display("done release");
  endtask
  task automatic t_press;
    // Two keys held: request timing, chip enable, read and rescan
    put(30'h2000_0080, 1'b0);
    wait_req(6500);
    chk("req time", n >= 6110 && n <= 6190, 1'b1);
    put(30'h2000_0080, 1'b1);
    chk("ce release", req_line, 1'b1);
    put(30'h2000_0080, 1'b0);
    chk("req kept", req_line, 1'b0);
    rd(`KMS_OFF_KEYS);
    chk("keys", d[29:0], 30'h2000_0080);
    chk("req clear", req_line, 1'b1);
    wait_req(6500);
    chk("rescan", n >= 6110 && n <= 6190, 1'b1);
    put(30'h0, 1'b0);
    rd(`KMS_OFF_KEYS);
    wait_req(6500);
    chk("idle", req_line, 1'b1);
    $display("done press");
  endtask
  task automatic t_disable;
    // Disable with request pending, while idle and during a scan
    put(30'h7, 1'b0);
    wait_req(6500);
    wr(`KMS_OFF_CTRL, 32'h8);
    chk("dis drop", req_line, 1'b1);
    rd(`KMS_OFF_KEYS);
    chk("keys zero", d[29:0], 30'h0);
    wait_req(6500);
    chk("no scan", req_line, 1'b1);
    wr(`KMS_OFF_CTRL, 32'h0);
    wait_req(6500);
    chk("enable", req_line, 1'b0);
    rd(`KMS_OFF_KEYS);
    chk("triple", d[29:0], 30'h7);
    // Controller side: this word has three or more set bits, so it may be dropped
    chk("discard", $countones(d[29:0]) >= 3, 1'b1);
    tick(1000);
    rd(`KMS_OFF_STATUS);
    chk("scanning", d[`KMS_ST_SCAN_BIT], 1'b1);
    wr(`KMS_OFF_CTRL, 32'h8);
    rd(`KMS_OFF_STATUS);
    chk("scan halted", d[`KMS_ST_SCAN_BIT], 1'b0);
    wait_req(6500);
    chk("scan stop", req_line, 1'b1);
    put(30'h0, 1'b0);
    $display("done disable");
  endtask
  task automatic t_sleep;
    // Sleep with only line six high, wake on a press
    wr(`KMS_OFF_CTRL, 32'h15);
    chk("sleep lines", scan_drive_lines, 6'h20);
    chk("sleep blank", display_on, 1'b0);
    tick(20);
    chk("osc stop", osc_run, 1'b0);
    put(30'h0400_0000, 1'b0);
    chk("osc wake", osc_run, 1'b1);
    wait_req(6500);
    chk("req sleep", req_line, 1'b0);
    rd(`KMS_OFF_KEYS);
    chk("sleep keys", d, 32'h8400_0000);
    rd(`KMS_OFF_CTRL);
    chk("sleep kept", d[5:0], 6'h15);
    put(30'h0, 1'b0);
    wait_req(6500);
    wr(`KMS_OFF_CTRL, 32'h20);
    chk("osc sel", osc_source_select, 1'b1);
    $display("done sleep");
  endtask
  task automatic t_drop;
    // Supply drop during a pending request
    put(30'h1, 1'b0);
    wait_req(6500);
    supply_drop_detector <= 1'b1;
    tick(1);
    supply_drop_detector <= 1'b0;
    chk("drop req", req_line, 1'b1);
    chk("drop disp", display_on, 1'b0);
    rd(`KMS_OFF_KEYS);
    chk("drop keys", d[29:0], 30'h0);
    $display("done drop");
  endtask

  // ********************
  // Main sequence
  // ********************
  initial begin
    lut = '{`KMS_CFG0, `KMS_CFG1, `KMS_CFG2, `KMS_CFG3,
            `KMS_CFG4, `KMS_CFG5, `KMS_CFG6, `KMS_CFG7};
    {reset_n, reg_wr, reg_rd, reg_addr, reg_wdata, pressed, chip_enable} = '0;
    {supply_drop_detector, disp_data_done} = 2'b00;
    repeat (16) @(posedge clock);
    reset_n <= 1'b1;
    tick(4);
    t_reset_lines;
    t_release;
    t_press;
    t_disable;
    t_sleep;
    t_drop;
    print_verdict;
  end

  // Watchdog over the expected run length
  initial begin
    repeat (90000) @(posedge clock);
    err_count++;
    print_verdict;
  end
endmodule // kms_scan_tb_top

bind kms_scan kms_scan_chk kms_scan_chk_inst (
  .clock(clock), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .scan_drive_lines(scan_drive_lines),
  .chip_enable(chip_enable), .key_req_n_o(key_req_n_o), .key_req_n_oe(key_req_n_oe),
  .supply_drop_detector(supply_drop_detector), .display_on(display_on),
  .disp_clk_en(disp_clk_en));
